// ### core/sma_defines.vh
// Constants for the switch monitor alert line block
`ifndef SMA_DEFINES_VH
`define SMA_DEFINES_VH
`define SMA_CLK_MHZ 100
`define SMA_ACTIVE_US 2
`define SMA_INACTIVE_US 2
`define SMA_IDLE_US 1
`define SMA_ACTIVE_CYC (`SMA_ACTIVE_US * `SMA_CLK_MHZ)
`define SMA_INACTIVE_CYC (`SMA_INACTIVE_US * `SMA_CLK_MHZ)
`define SMA_IDLE_CYC (`SMA_IDLE_US * `SMA_CLK_MHZ)
`define SMA_SCHEME_STATIC 1'b0
`define SMA_SCHEME_DYNAMIC 1'b1
`define SMA_CNT_W 16
`define SMA_EVT_W 8
`endif

// ### core/sma_alert.v
// Alert line controller with static and dynamic schemes and idle hold-off
`timescale 1ns/1ps
`default_nettype none
`include "sma_defines.vh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Alert pin is active-low open-drain, pulled low on any unmasked event.
// - Scheme bit: 0 static, 1 dynamic toggling.
// - Static: alert stays low until chip-select rises after an event-flag read.
// - Flags latched at first SCLK rise per transaction; cleared by a flag read.
// - Dynamic: low for active window, then released if flags unread.
// - Dynamic: after inactive window go low again, repeat until read.
// - Dynamic read while low releases alert and clears flags at CS rise.
// - Dynamic read while high clears flags; alert not driven low again.
// - Scheme selection resets to static.
// - Scheme changes only accepted while run-control bit is 0.
// - Flag read with unmasked pending event starts idle hold-off.
// - Events during hold-off update flags now, alert delayed until expiry.
// - Read during hold-off clears flags; no alert at hold-off end; code still alerts for an earlier event if read in the last hold-off cycle.
// - Alert high-impedance before wake event; monitoring continues without SPI.
// - Host wake-up via alert only with static scheme.
module sma_alert #(
  parameter EVT_W = `SMA_EVT_W,
  parameter CNT_W = `SMA_CNT_W,
  parameter [`SMA_CNT_W-1:0] ACTIVE_CYC = `SMA_ACTIVE_CYC,
  parameter [`SMA_CNT_W-1:0] INACTIVE_CYC = `SMA_INACTIVE_CYC,
  parameter [`SMA_CNT_W-1:0] IDLE_CYC = `SMA_IDLE_CYC
) (
  // Clock and reset
  input wire i_clock,
  input wire i_sys_rst,
  // Event sources, one-cycle pulses per flag bit
  input wire [EVT_W-1:0] i_event,
  input wire [EVT_W-1:0] i_event_mask,
  // Control
  input wire i_scheme_sel,
  input wire i_run,
  // SPI transaction markers
  input wire i_cs_fall,
  input wire i_sclk_rise,
  input wire i_cs_rise,
  input wire i_flag_read_cmd,
  // Event flags
  output reg [EVT_W-1:0] o_flags,
  output reg [EVT_W-1:0] o_flags_latched,
  output reg o_scheme,
  // Open-drain alert pin
  output wire o_alert_out,
  output wire o_alert_oe
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_LOW = 2'd1;
  localparam [1:0] ST_HIGH = 2'd2;
  localparam [1:0] ST_HOLD = 2'd3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg first_clk_reg;
  reg read_seen_reg;
  reg hold_pend_reg;
  reg hold_pend_next;
  wire any_evt;
  wire read_done;
  wire pending;

  assign any_evt = |(i_event & ~i_event_mask);
  // Read completes on chip-select rise of a flag-read transaction
  assign read_done = i_cs_rise & (read_seen_reg | i_flag_read_cmd);
  assign pending = |(o_flags & ~i_event_mask);

  //////////////////////////////////////////////////////////////////////////////
  // Static by default
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_scheme <= `SMA_SCHEME_STATIC;
    end else if (!i_run) begin
      o_scheme <= i_scheme_sel;
    end
  end

  // Flags and transaction tracking
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_flags <= {EVT_W{1'b0}};
      o_flags_latched <= {EVT_W{1'b0}};
      first_clk_reg <= 1'b0;
      read_seen_reg <= 1'b0;
    end else begin
      if (i_cs_fall) begin
        first_clk_reg <= 1'b1;
      end else if (i_sclk_rise) begin
        first_clk_reg <= 1'b0;
      end
      if (i_sclk_rise && first_clk_reg) begin
        o_flags_latched <= o_flags;
      end
      if (i_cs_rise) begin
        read_seen_reg <= 1'b0;
      end else if (i_flag_read_cmd) begin
        read_seen_reg <= 1'b1;
      end
      // Flags update at once; new events win over clear
      if (read_done) begin
        o_flags <= i_event;
      end else begin
        o_flags <= o_flags | i_event;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alert sequencer
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hold_pend_next = hold_pend_reg;
    case (state_reg)
      ST_IDLE: begin
        if (any_evt) begin
          state_next = ST_LOW;
          cnt_next = ACTIVE_CYC;
        end
      end
      ST_LOW: begin
        if (read_done) begin
          state_next = ST_HOLD;
          cnt_next = IDLE_CYC;
          hold_pend_next = any_evt;
        end else if (o_scheme == `SMA_SCHEME_DYNAMIC) begin
          if (cnt_reg <= 1) begin
            state_next = ST_HIGH;
            cnt_next = INACTIVE_CYC;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
      end
      ST_HIGH: begin
        if (read_done) begin
          state_next = ST_HOLD;
          cnt_next = IDLE_CYC;
          hold_pend_next = any_evt;
        end else if (cnt_reg <= 1) begin
          state_next = ST_LOW;
          cnt_next = ACTIVE_CYC;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ST_HOLD: begin
        // Read before the last hold-off cycle drops pending alert
        if (read_done) begin
          hold_pend_next = any_evt;
        end else if (any_evt) begin
          hold_pend_next = 1'b1;
        end
        if (cnt_reg <= 1) begin
          if (hold_pend_reg || (any_evt && !read_done) || (pending && !read_done && hold_pend_reg)) begin
            state_next = ST_LOW;
            cnt_next = ACTIVE_CYC;
          end else begin
            state_next = ST_IDLE;
          end
          hold_pend_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= {CNT_W{1'b0}};
      hold_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hold_pend_reg <= hold_pend_next;
    end
  end

  // Wake path relies on static hold-low
  // Released (high-Z) unless asserting; pull-up or wake path sets level
  assign o_alert_out = 1'b0;
  // Release follows the read state change
  assign o_alert_oe = (state_reg == ST_LOW);

endmodule
`default_nettype wire

// ### dv/sma_alert_asserts.sv
// Checker for the alert line controller
`timescale 1ns/1ps
`default_nettype none
module sma_alert_asserts #(parameter [15:0] ACTIVE_CYC = 16'h10) (
  // Clock, reset, control
  input wire logic i_clock, i_sys_rst, i_scheme_sel, i_run,
  // Transaction markers
  input wire logic i_cs_fall, i_sclk_rise, i_cs_rise, i_flag_read_cmd,
  // Events and flags
  input wire logic [7:0] i_event, i_event_mask, o_flags, o_flags_latched,
  // Alert pin
  input wire logic o_scheme, o_alert_out, o_alert_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  drive_low_a: assert property (o_alert_out == 1'b0) else $error("pin");
  flag_set_a: assert property (i_event != 8'h0 |=> (o_flags & $past(i_event)) == $past(i_event))
    else $error("flag");
  latch_snap_a: assert property ($past(i_cs_fall) && i_sclk_rise |=> o_flags_latched == $past(o_flags))
    else $error("latch");
  scheme_lock_a: assert property (i_run |=> $stable(o_scheme)) else $error("lock");
  scheme_take_a: assert property (!i_run |=> o_scheme == $past(i_scheme_sel)) else $error("take");
  reset_def_a: assert property ($past(i_sys_rst) |-> !o_scheme && !o_alert_oe && o_flags == 8'h0)
    else $error("reset");
  static_rel_a: assert property ($fell(o_alert_oe) && !o_scheme |-> $past(i_cs_rise))
    else $error("static");
  dyn_window_a: assert property ($fell(o_alert_oe) && o_scheme && !$past(i_cs_rise) |->
    $past(o_alert_oe, ACTIVE_CYC) && !$past(o_alert_oe, ACTIVE_CYC + 1)) else $error("window");
  idle_hold_a: assert property ($fell(o_alert_oe) && $past(i_cs_rise) |-> (!o_alert_oe) [*3])
    else $error("idle");
endmodule
bind sma_alert sma_alert_asserts #(.ACTIVE_CYC(ACTIVE_CYC)) u_chk (.*);
`default_nettype wire

// ### dv/sma_host.sv
// Host model issuing event-flag transactions
`timescale 1ns/1ps
`default_nettype none
module sma_host (
  input wire logic i_clock, i_go, i_rd,
  output logic o_cs_fall, o_sclk_rise, o_rd_cmd, o_cs_rise, o_host_regulator_hold
);
  int st = 0;
  always @(posedge i_clock) st <= (st == 0) ? int'(i_go) : (st + 1) % 5;
  assign o_cs_fall = st == 1;
  assign o_sclk_rise = st == 2;
  assign o_rd_cmd = st == 3 && i_rd;
  assign o_cs_rise = st == 4;
  assign o_host_regulator_hold = 1'b1;
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the alert line controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clock = 0, i_sys_rst = 1, i_scheme_sel = 0, i_run = 0, go = 0, rd = 0;
  logic [7:0] i_event = 0, i_event_mask = 0, v, exp_f = 0;
  wire [7:0] o_flags, o_flags_latched;
  wire o_scheme, o_alert_out, o_alert_oe, i_cs_fall, i_sclk_rise, i_flag_read_cmd, i_cs_rise;
  int error_cnt = 0, num_checks = 0, seed = 21;
  always #5 i_clock = ~i_clock;
  sma_alert #(.ACTIVE_CYC(16'h8), .INACTIVE_CYC(16'h8), .IDLE_CYC(16'hc)) u_dut (.*);
  sma_host u_host (.i_clock(i_clock), .i_go(go), .i_rd(rd), .o_cs_fall(i_cs_fall), .o_sclk_rise(i_sclk_rise),
    .o_rd_cmd(i_flag_read_cmd), .o_cs_rise(i_cs_rise), .o_host_regulator_hold());
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic pulse(input logic [7:0] m);
    v = 8'h1 << ($unsigned($random(seed)) % 8);
    exp_f = exp_f | v;
    @(posedge i_clock);
    i_event <= v;
    i_event_mask <= m;
    @(posedge i_clock);
    i_event <= 8'h0;
    #1;
    chk("flags", o_flags, exp_f);
  endtask
  task automatic xfer(input logic r);
    @(posedge i_clock);
    go <= 1'b1;
    rd <= r;
    @(posedge i_clock);
    go <= 1'b0;
    tick(4);
    if (r) exp_f = 8'h0;
    chk("flags", o_flags, exp_f);
  endtask
  task automatic conclude;
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    tick(1);
    chk("scheme", o_scheme, 8'h0);
    chk("oe", o_alert_oe, 8'h0);
    pulse(8'h0);
    chk("oe", o_alert_oe, 8'h1);
    xfer(1'b0);
    chk("latched", o_flags_latched, exp_f);
    chk("oe", o_alert_oe, 8'h1);
    xfer(1'b1);
    chk("oe", o_alert_oe, 8'h0);
    pulse(8'h0);
    chk("oe", o_alert_oe, 8'h0);
    tick(12);
    chk("oe", o_alert_oe, 8'h1);
    xfer(1'b1);
    pulse(8'h0);
    xfer(1'b1);
    tick(12);
    chk("oe", o_alert_oe, 8'h0);
    pulse(8'hff);
    tick(2);
    chk("oe", o_alert_oe, 8'h0);
    xfer(1'b1);
    i_event_mask <= 8'h0;
    i_run <= 1'b1;
    i_scheme_sel <= 1'b1;
    tick(2);
    chk("scheme", o_scheme, 8'h0);
    i_run <= 1'b0;
    tick(2);
    chk("scheme", o_scheme, 8'h1);
    pulse(8'h0);
    tick(8);
    chk("oe", o_alert_oe, 8'h0);
    tick(8);
    chk("oe", o_alert_oe, 8'h1);
    xfer(1'b1);
    chk("oe", o_alert_oe, 8'h0);
    tick(12);
    pulse(8'h0);
    tick(8);
    xfer(1'b1);
    tick(4);
    chk("oe", o_alert_oe, 8'h0);
    tick(8);
    chk("oe", o_alert_oe, 8'h0);
    conclude();
  end
endmodule
`default_nettype wire
